// ==== design/ccc_pkg.sv ====
// Constants and types of the crypto capability configuration space.
// Assumes an AHB-Lite master on the one clock; capability values are set
// by the parameters of the top module and stay fixed between resets.
package ccc_pkg;
  // Byte offsets of the configuration structure, one word each
  localparam logic [7:0] OFS_READINESS     = 8'h00;
  localparam logic [7:0] OFS_QUEUE_LIMIT   = 8'h04;
  localparam logic [7:0] OFS_SERVICES      = 8'h08;
  localparam logic [7:0] OFS_ENC_LOW       = 8'h0c;
  localparam logic [7:0] OFS_ENC_HIGH      = 8'h10;
  localparam logic [7:0] OFS_DIGEST        = 8'h14;
  localparam logic [7:0] OFS_AUTH_LOW      = 8'h18;
  localparam logic [7:0] OFS_AUTH_HIGH     = 8'h1c;
  localparam logic [7:0] OFS_AEAD          = 8'h20;
  localparam logic [7:0] OFS_ENC_KEY       = 8'h24;
  localparam logic [7:0] OFS_AUTH_KEY      = 8'h28;
  localparam logic [7:0] OFS_RESERVED      = 8'h2c;
  localparam logic [7:0] OFS_SIZE_LOW      = 8'h30;
  localparam logic [7:0] OFS_SIZE_HIGH     = 8'h34;
  // Request pre-check window
  localparam logic [7:0] OFS_REQ_SELECT    = 8'h40;
  localparam logic [7:0] OFS_REQ_KEY       = 8'h44;
  localparam logic [7:0] OFS_REQ_SIZE_LOW  = 8'h48;
  localparam logic [7:0] OFS_REQ_SIZE_HIGH = 8'h4c;
  localparam logic [7:0] OFS_REQ_CHECK     = 8'h50;

  localparam int READY_BIT      = 0;
  localparam int SEL_SVC_LSB    = 0;
  localparam int SEL_ALG_LSB    = 8;
  localparam int CHK_DONE_BIT   = 0;
  localparam int CHK_PASS_BIT   = 1;
  localparam int CHK_REASON_LSB = 4;

  // Service codes, used as bit numbers of the service offer mask
  localparam logic [1:0] SVC_CIPHER = 2'h0;
  localparam logic [1:0] SVC_HASH   = 2'h1;
  localparam logic [1:0] SVC_MAC    = 2'h2;
  localparam logic [1:0] SVC_AEAD   = 2'h3;

  // Bits that name a defined algorithm
  localparam logic [31:0] DEF_ENC_LOW   = 32'h00007ffe;
  localparam logic [31:0] DEF_ENC_HIGH  = 32'h00000000;
  localparam logic [31:0] DEF_DIGEST    = 32'h00001ffe;
  localparam logic [31:0] DEF_AUTH_LOW  = 32'h1e00007e;
  localparam logic [31:0] DEF_AUTH_HIGH = 32'h00660600;
  localparam logic [31:0] DEF_AEAD      = 32'h0000000e;
  localparam logic [3:0]  DEF_SERVICES  = 4'hf;

  // Capability defaults
  localparam logic [31:0] RST_QUEUE_LIMIT = 32'h00000004;
  localparam logic [3:0]  RST_SERVICES    = 4'hf;
  localparam logic [31:0] RST_ENC_LOW     = 32'h0000003e;
  localparam logic [31:0] RST_ENC_HIGH    = 32'h00000000;
  localparam logic [31:0] RST_DIGEST      = 32'h0000001e;
  localparam logic [31:0] RST_AUTH_LOW    = 32'h0000001e;
  localparam logic [31:0] RST_AUTH_HIGH   = 32'h00000000;
  localparam logic [31:0] RST_AEAD        = 32'h00000006;
  localparam logic [31:0] RST_ENC_KEY     = 32'h00000040;
  localparam logic [31:0] RST_AUTH_KEY    = 32'h00000080;
  localparam logic [63:0] RST_SIZE_LIMIT  = 64'h0000000000010000;
  localparam logic [31:0] RST_WORD        = 32'h00000000;

  // Verdict reasons
  localparam logic [3:0] WHY_OK        = 4'h0;
  localparam logic [3:0] WHY_NOT_READY = 4'h1;
  localparam logic [3:0] WHY_NO_SVC    = 4'h2;
  localparam logic [3:0] WHY_BAD_ALG   = 4'h3;
  localparam logic [3:0] WHY_KEY_LONG  = 4'h4;
  localparam logic [3:0] WHY_TOO_BIG   = 4'h5;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

  typedef struct packed {
    logic [1:0]  svc;
    logic [7:0]  alg;
    logic [31:0] key_len;
    logic [63:0] size;
  } ccc_req_type;

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        ready;
    logic        halted;
    logic        hready;
    logic        hresp;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    ccc_req_type req;
    logic        done;
    logic        pass;
    logic [3:0]  reason;
    logic [1:0]  age;
  } ccc_state_type;
endpackage

// ==== design/ccc_config_space.sv ====
// Crypto capability configuration space behind an AHB-Lite slave port.
// Assumes one master, whole-word single transfers, and an engine-ready
// level from another clock domain on I_ENGINE_READY.
module ccc_config_space #(
  parameter logic [31:0] CAP_QUEUE_LIMIT = ccc_pkg::RST_QUEUE_LIMIT,
  parameter logic [3:0]  CAP_SERVICES    = ccc_pkg::RST_SERVICES,
  parameter logic [31:0] CAP_ENC_LOW     = ccc_pkg::RST_ENC_LOW,
  parameter logic [31:0] CAP_ENC_HIGH    = ccc_pkg::RST_ENC_HIGH,
  parameter logic [31:0] CAP_DIGEST      = ccc_pkg::RST_DIGEST,
  parameter logic [31:0] CAP_AUTH_LOW    = ccc_pkg::RST_AUTH_LOW,
  parameter logic [31:0] CAP_AUTH_HIGH   = ccc_pkg::RST_AUTH_HIGH,
  parameter logic [31:0] CAP_AEAD        = ccc_pkg::RST_AEAD,
  parameter logic [31:0] CAP_ENC_KEY     = ccc_pkg::RST_ENC_KEY,
  parameter logic [31:0] CAP_AUTH_KEY    = ccc_pkg::RST_AUTH_KEY,
  parameter logic [63:0] CAP_SIZE_LIMIT  = ccc_pkg::RST_SIZE_LIMIT
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_ENGINE_READY,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  output logic             O_DEVICE_READY
);

  // Queue limit is forced into its legal range whatever the parameter says
  function automatic logic [31:0] clamp_queues(input logic [31:0] q);
    if (q == 32'h0) begin
      clamp_queues = 32'h1;
    end else if (q > 32'h0000ffff) begin
      clamp_queues = 32'h0000ffff;
    end else begin
      clamp_queues = q;
    end
  endfunction

  localparam logic [3:0] SVC = CAP_SERVICES & ccc_pkg::DEF_SERVICES;

  // A service that is not offered reports an empty mask; a key limit reads zero only if no service using it is offered
  localparam logic [31:0] ENC_L  = SVC[0] ? (CAP_ENC_LOW & ccc_pkg::DEF_ENC_LOW) : 32'h0;
  localparam logic [31:0] ENC_H  = SVC[0] ? (CAP_ENC_HIGH & ccc_pkg::DEF_ENC_HIGH) : 32'h0;
  localparam logic [31:0] DIG    = SVC[1] ? (CAP_DIGEST & ccc_pkg::DEF_DIGEST) : 32'h0;
  localparam logic [31:0] AUTH_L = SVC[2] ? (CAP_AUTH_LOW & ccc_pkg::DEF_AUTH_LOW) : 32'h0;
  localparam logic [31:0] AUTH_H = SVC[2] ? (CAP_AUTH_HIGH & ccc_pkg::DEF_AUTH_HIGH) : 32'h0;
  localparam logic [31:0] AEAD   = SVC[3] ? (CAP_AEAD & ccc_pkg::DEF_AEAD) : 32'h0;
  localparam logic [31:0] QUEUES = clamp_queues(CAP_QUEUE_LIMIT);
  localparam logic [31:0] ENC_KEY  = (SVC[0] || SVC[3]) ? CAP_ENC_KEY : 32'h0;
  localparam logic [31:0] AUTH_KEY = SVC[2] ? CAP_AUTH_KEY : 32'h0;

  localparam int SEL_SVC_HI    = ccc_pkg::SEL_SVC_LSB + 1;
  localparam int SEL_ALG_HI    = ccc_pkg::SEL_ALG_LSB + 7;
  localparam int CHK_REASON_HI = ccc_pkg::CHK_REASON_LSB + 3;

  localparam ccc_pkg::ccc_state_type ST_RESET = '{hready: 1'b1, default: '0};

  ccc_pkg::ccc_state_type st;
  ccc_pkg::ccc_state_type next_st;

  logic       take;
  logic       rd_take;
  logic [7:0] rd_addr;

  // The 64-bit mask of a service, indexed by algorithm code
  function automatic logic [63:0] svc_mask(input logic [1:0] s);
    case (s)
      ccc_pkg::SVC_CIPHER: svc_mask = {ENC_H, ENC_L};
      ccc_pkg::SVC_HASH:   svc_mask = {32'h0, DIG};
      ccc_pkg::SVC_MAC:    svc_mask = {AUTH_H, AUTH_L};
      ccc_pkg::SVC_AEAD:   svc_mask = {32'h0, AEAD};
      default:             svc_mask = 64'h0;
    endcase
  endfunction

  // Checks a request the way the engine will; first failure wins
  function automatic logic [3:0] judge(input ccc_pkg::ccc_req_type r,
                                       input logic rdy);
    logic [63:0] m;
    logic        key_long;
    m = svc_mask(r.svc);
    key_long = 1'b0;
    case (r.svc)
      ccc_pkg::SVC_CIPHER: key_long = r.key_len > ENC_KEY;
      ccc_pkg::SVC_AEAD:   key_long = r.key_len > ENC_KEY;
      ccc_pkg::SVC_MAC:    key_long = r.key_len > AUTH_KEY;
      default:             key_long = 1'b0;
    endcase
    if (!rdy) begin
      judge = ccc_pkg::WHY_NOT_READY;
    end else if (!SVC[r.svc]) begin
      judge = ccc_pkg::WHY_NO_SVC;
    end else if (r.alg == 8'h0 || r.alg[7:6] != 2'h0 || !m[r.alg[5:0]]) begin
      judge = ccc_pkg::WHY_BAD_ALG;
    end else if (key_long) begin
      judge = ccc_pkg::WHY_KEY_LONG;
    end else if (r.size > CAP_SIZE_LIMIT) begin
      judge = ccc_pkg::WHY_TOO_BIG;
    end else begin
      judge = ccc_pkg::WHY_OK;
    end
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input ccc_pkg::ccc_state_type s);
    read_word = ccc_pkg::RST_WORD;
    case (a)
      ccc_pkg::OFS_READINESS:     read_word[ccc_pkg::READY_BIT] = s.ready;
      ccc_pkg::OFS_QUEUE_LIMIT:   read_word = QUEUES;
      ccc_pkg::OFS_SERVICES:      read_word = {28'h0, SVC};
      ccc_pkg::OFS_ENC_LOW:       read_word = ENC_L;
      ccc_pkg::OFS_ENC_HIGH:      read_word = ENC_H;
      ccc_pkg::OFS_DIGEST:        read_word = DIG;
      ccc_pkg::OFS_AUTH_LOW:      read_word = AUTH_L;
      ccc_pkg::OFS_AUTH_HIGH:     read_word = AUTH_H;
      ccc_pkg::OFS_AEAD:          read_word = AEAD;
      ccc_pkg::OFS_ENC_KEY:       read_word = ENC_KEY;
      ccc_pkg::OFS_AUTH_KEY:      read_word = AUTH_KEY;
      ccc_pkg::OFS_RESERVED:      read_word = ccc_pkg::RST_WORD;
      ccc_pkg::OFS_SIZE_LOW:      read_word = CAP_SIZE_LIMIT[31:0];
      ccc_pkg::OFS_SIZE_HIGH:     read_word = CAP_SIZE_LIMIT[63:32];
      ccc_pkg::OFS_REQ_SELECT: begin
        read_word[SEL_SVC_HI:ccc_pkg::SEL_SVC_LSB] = s.req.svc;
        read_word[SEL_ALG_HI:ccc_pkg::SEL_ALG_LSB] = s.req.alg;
      end
      ccc_pkg::OFS_REQ_KEY:       read_word = s.req.key_len;
      ccc_pkg::OFS_REQ_SIZE_LOW:  read_word = s.req.size[31:0];
      ccc_pkg::OFS_REQ_SIZE_HIGH: read_word = s.req.size[63:32];
      ccc_pkg::OFS_REQ_CHECK: begin
        read_word[ccc_pkg::CHK_DONE_BIT] = s.done;
        read_word[ccc_pkg::CHK_PASS_BIT] = s.pass;
        read_word[CHK_REASON_HI:ccc_pkg::CHK_REASON_LSB] = s.reason;
      end
      default:                    read_word = ccc_pkg::RST_WORD;
    endcase
  endfunction

  assign take    = I_HSEL && I_HREADY && I_HTRANS[1];
  assign rd_take = take && !I_HWRITE;
  assign rd_addr = I_HADDR[7:0];

  always_comb begin
    next_st = st;
    // Only sync1 reads the pin; a lone flop could go metastable
    next_st.sync1  = I_ENGINE_READY;
    next_st.sync2  = st.sync1;
    next_st.ready  = st.sync2 && !st.halted;
    next_st.hready = 1'b1;
    next_st.hresp  = 1'b0;
    next_st.age    = (st.age == 2'h3) ? st.age : st.age + 2'h1;
    // Zero wait states: read data is fetched in the address phase
    next_st.wr_pend = take && I_HWRITE && (I_HSIZE == ccc_pkg::HSIZE_WORD);
    next_st.wr_addr = take ? I_HADDR[7:0] : st.wr_addr;
    next_st.rdata   = rd_take ? read_word(rd_addr, st) : ccc_pkg::RST_WORD;
    if (st.wr_pend) begin
      case (st.wr_addr)
        ccc_pkg::OFS_REQ_SELECT: begin
          next_st.req.svc = I_HWDATA[SEL_SVC_HI:ccc_pkg::SEL_SVC_LSB];
          next_st.req.alg = I_HWDATA[SEL_ALG_HI:ccc_pkg::SEL_ALG_LSB];
          next_st.done    = 1'b0;
        end
        ccc_pkg::OFS_REQ_KEY: begin
          next_st.req.key_len = I_HWDATA;
          next_st.done        = 1'b0;
        end
        ccc_pkg::OFS_REQ_SIZE_LOW: begin
          next_st.req.size[31:0] = I_HWDATA;
          next_st.done           = 1'b0;
        end
        ccc_pkg::OFS_REQ_SIZE_HIGH: begin
          next_st.req.size[63:32] = I_HWDATA;
          next_st.done            = 1'b0;
        end
        ccc_pkg::OFS_REQ_CHECK: begin
          next_st.done   = 1'b1;
          next_st.reason = judge(st.req, st.ready);
          next_st.pass   = judge(st.req, st.ready) == ccc_pkg::WHY_OK;
          // An oversized request leaves the device unusable until reset
          // Oversize halts while ready, even when the service, algorithm or key check already refused the request
          if (st.ready && st.req.size > CAP_SIZE_LIMIT) begin
            next_st.halted = 1'b1;
          end
        end
        default: next_st.done = st.done;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign O_HRDATA       = st.rdata;
  assign O_HREADYOUT    = st.hready;
  assign O_HRESP        = st.hresp;
  assign O_DEVICE_READY = st.ready;

  a_ready_follows: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st.age == 2'h3 && !$past(st.halted)) |-> O_DEVICE_READY == $past(I_ENGINE_READY, 3))
    else $error("ready flag does not follow engine ready");

  a_ready_word_clean: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (rd_take && rd_addr == ccc_pkg::OFS_READINESS)
    |=> O_HRDATA[31:1] == 31'h0 && O_HRDATA[0] == $past(st.ready))
    else $error("readiness word wrong");

  a_queue_range: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (rd_take && rd_addr == ccc_pkg::OFS_QUEUE_LIMIT)
    |=> O_HRDATA >= 32'h1 && O_HRDATA <= 32'h0000ffff)
    else $error("queue limit out of range");

  a_service_bits: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (rd_take && rd_addr == ccc_pkg::OFS_SERVICES) |=> O_HRDATA[31:4] == 28'h0)
    else $error("service mask has stray bits");

  a_enc_mask_defined: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (rd_take && rd_addr == ccc_pkg::OFS_ENC_LOW)
    |=> (O_HRDATA & ~ccc_pkg::DEF_ENC_LOW) == 32'h0)
    else $error("cipher mask sets undefined bit");

  a_auth_high_defined: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (rd_take && rd_addr == ccc_pkg::OFS_AUTH_HIGH)
    |=> (O_HRDATA & ~ccc_pkg::DEF_AUTH_HIGH) == 32'h0)
    else $error("authentication high mask sets undefined bit");

  a_reserved_zero: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (rd_take && rd_addr == ccc_pkg::OFS_RESERVED) |=> O_HRDATA == 32'h0)
    else $error("reserved word not zero");

  a_size_limit: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (rd_take && rd_addr == ccc_pkg::OFS_SIZE_HIGH) |=> O_HRDATA == CAP_SIZE_LIMIT[63:32])
    else $error("size limit high word wrong");

  a_oversize_fails: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st.wr_pend && st.wr_addr == ccc_pkg::OFS_REQ_CHECK && st.ready
     && st.req.size > CAP_SIZE_LIMIT) |=> st.done && !st.pass ##2 !O_DEVICE_READY)
    else $error("oversized request not failed");

  a_enc_key_fails: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st.wr_pend && st.wr_addr == ccc_pkg::OFS_REQ_CHECK
     && st.req.svc == ccc_pkg::SVC_CIPHER && st.req.key_len > ENC_KEY) |=> !st.pass)
    else $error("long cipher key passed");

  a_auth_key_fails: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st.wr_pend && st.wr_addr == ccc_pkg::OFS_REQ_CHECK
     && st.req.svc == ccc_pkg::SVC_MAC && st.req.key_len > AUTH_KEY) |=> !st.pass)
    else $error("long authentication key passed");

  a_ready_accepts: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st.wr_pend && st.wr_addr == ccc_pkg::OFS_REQ_CHECK && st.ready
     && judge(st.req, 1'b1) == ccc_pkg::WHY_OK) |=> st.pass && st.reason == ccc_pkg::WHY_OK)
    else $error("valid request refused while ready");

endmodule

// ==== dv/ccc_drv_model.sv ====
// Guest driver model: AHB-Lite master that discovers and pre-checks requests.
// Assumes one slave whose hreadyout comes back on i_hready.
module ccc_drv_model (
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [31:0] o_hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_hsel   = 1'b0;
    o_haddr  = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize  = ccc_pkg::HSIZE_WORD;
    o_hwdata = 32'h0;
  end
  // Hold the address phase until hready, then the data phase until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge i_clk);
    o_hsel   <= 1'b1;
    o_haddr  <= {24'h0, a};
    o_htrans <= ccc_pkg::HTRANS_NONSEQ;
    o_hwrite <= w;
    @(posedge i_clk);
    while (i_hready !== 1'b1) @(posedge i_clk);
    o_htrans <= 2'h0;
    o_hwdata <= wd;
    @(posedge i_clk);
    while (i_hready !== 1'b1) @(posedge i_clk);
    rd = i_hrdata;
  endtask
  // Words 0 to 2 first, then each later word only if its service is offered or it belongs to no service
  task automatic discover(output logic [31:0] v[14]);
    logic [3:0] need;
    for (int i = 0; i < 14; i++) begin
      v[i] = 32'h0;
      need = (i inside {3, 4, 9}) ? 4'h1 : (i == 5) ? 4'h2 :
             (i inside {6, 7, 10}) ? 4'h4 : (i == 8) ? 4'h8 : 4'h0;
      if (i < 3 || (v[2][3:0] & need) != 4'h0 || need == 4'h0) begin
        xfer(1'b0, 8'(4 * i), 32'h0, v[i]);
      end
    end
  endtask
  // Nothing is submitted unless the ready flag reads set, except on purpose
  task automatic submit(input logic [1:0] s, input logic [7:0] a, input logic [31:0] k,
                        input logic [63:0] z, input logic insist, output logic [31:0] rd);
    xfer(1'b0, ccc_pkg::OFS_READINESS, 32'h0, rd);
    if (rd[ccc_pkg::READY_BIT] !== 1'b1 && !insist) begin
      rd = 32'h0;
      return;
    end
    xfer(1'b1, ccc_pkg::OFS_REQ_SELECT, {16'h0, a, 6'h0, s}, rd);
    xfer(1'b1, ccc_pkg::OFS_REQ_KEY, k, rd);
    xfer(1'b1, ccc_pkg::OFS_REQ_SIZE_LOW, z[31:0], rd);
    xfer(1'b1, ccc_pkg::OFS_REQ_SIZE_HIGH, z[63:32], rd);
    xfer(1'b1, ccc_pkg::OFS_REQ_CHECK, 32'h0, rd);
    xfer(1'b0, ccc_pkg::OFS_REQ_CHECK, 32'h0, rd);
  endtask
endmodule

// ==== dv/tb_crypto_capability_config.sv ====
// Self-checking bench of the capability space, default capability set.
// Assumes the driver model as sole bus master; engine ready from the bench.
module tb_crypto_capability_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst_n;
  logic        eng;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        dev_ready;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] cfg [14];
  logic [15:0] seed;
  logic [7:0]  algs [9] = '{8'd0, 8'd1, 8'd2, 8'd3, 8'd4, 8'd5, 8'd6, 8'd54, 8'd64};
  int          bad_count;
  int          checks;

  ccc_config_space dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ENGINE_READY(eng),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
    .O_HRESP(hresp), .O_DEVICE_READY(dev_ready));
  ccc_drv_model drv (.i_clk(clk), .i_hready(hreadyout), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Offered masks keep only defined bits
  function automatic logic [31:0] exp_word(int i);
    case (i)
      0: return 32'h1;
      1: return ccc_pkg::RST_QUEUE_LIMIT;
      2: return {28'h0, ccc_pkg::RST_SERVICES};
      3: return ccc_pkg::RST_ENC_LOW & ccc_pkg::DEF_ENC_LOW;
      4: return ccc_pkg::RST_ENC_HIGH & ccc_pkg::DEF_ENC_HIGH;
      5: return ccc_pkg::RST_DIGEST & ccc_pkg::DEF_DIGEST;
      6: return ccc_pkg::RST_AUTH_LOW & ccc_pkg::DEF_AUTH_LOW;
      7: return ccc_pkg::RST_AUTH_HIGH & ccc_pkg::DEF_AUTH_HIGH;
      8: return ccc_pkg::RST_AEAD & ccc_pkg::DEF_AEAD;
      9: return ccc_pkg::RST_ENC_KEY;
      10: return ccc_pkg::RST_AUTH_KEY;
      12: return ccc_pkg::RST_SIZE_LIMIT[31:0];
      13: return ccc_pkg::RST_SIZE_LIMIT[63:32];
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] key_lim(logic [1:0] s);
    return (s == 2'h2) ? ccc_pkg::RST_AUTH_KEY : (s == 2'h1) ? 32'hffffffff :
           ccc_pkg::RST_ENC_KEY;
  endfunction
  // Verdict word: done, pass, reason
  function automatic logic [31:0] verdict(logic r, logic [1:0] s, logic [7:0] a,
                                          logic [31:0] k, logic [63:0] z);
    logic [63:0] m;
    logic [3:0]  y;
    m = (s == 2'h0) ? {exp_word(4), exp_word(3)} : (s == 2'h1) ? {32'h0, exp_word(5)} :
        (s == 2'h2) ? {exp_word(7), exp_word(6)} : {32'h0, exp_word(8)};
    if (!r) y = ccc_pkg::WHY_NOT_READY;
    else if (!ccc_pkg::RST_SERVICES[s]) y = ccc_pkg::WHY_NO_SVC;
    else if (a > 8'd63 || !m[a[5:0]]) y = ccc_pkg::WHY_BAD_ALG;
    else if (k > key_lim(s)) y = ccc_pkg::WHY_KEY_LONG;
    else if (z > ccc_pkg::RST_SIZE_LIMIT) y = ccc_pkg::WHY_TOO_BIG;
    else y = ccc_pkg::WHY_OK;
    return {24'h0, y, 2'b00, y == ccc_pkg::WHY_OK, 1'b1};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic req(input logic r, input logic [1:0] s, input logic [7:0] a,
                     input logic [31:0] k, input logic [63:0] z);
    drv.submit(s, a, k, z, 1'b1, rd);
    chk({24'h0, rd[7:0]}, verdict(r, s, a, k, z), "verdict");
  endtask
  task automatic cfg_all(input string what);
    drv.discover(cfg);
    for (int i = 0; i < 14; i++) chk(cfg[i], exp_word(i), what);
  endtask
  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    eng = 1'b0;
    bad_count = 0;
    checks = 0;
    seed = 16'd55340;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    drv.xfer(1'b0, ccc_pkg::OFS_READINESS, 32'h0, rd);
    chk(rd, 32'h0, "ready before engine");
    req(1'b0, 2'h0, 8'd1, 32'h1, 64'h1);
    drv.submit(2'h1, 8'd2, 32'h0, 64'h1, 1'b0, rd);
    chk(rd, 32'h0, "refrained while not ready");
    drv.xfer(1'b0, ccc_pkg::OFS_REQ_CHECK, 32'h0, rd);
    chk(rd, verdict(1'b0, 2'h0, 8'd1, 32'h1, 64'h1), "verdict kept");
    $display("Test not_ready done");
    eng <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, dev_ready}, 32'h1, "ready pin");
    cfg_all("config word");
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      drv.xfer(1'b1, 8'(4 * i), {seed, ~seed}, rd);
    end
    cfg_all("after writes");
    drv.xfer(1'b0, 8'h3c, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "okay response");
    $display("Test config done");
    // Algorithm codes across each service with key limit and one past it; the hash limit is all ones, so one past wraps to zero
    for (int s = 0; s < 4; s++) begin
      for (int j = 0; j < 9; j++) begin
        req(1'b1, 2'(s), algs[j], key_lim(2'(s)), ccc_pkg::RST_SIZE_LIMIT);
        req(1'b1, 2'(s), algs[j], key_lim(2'(s)) + 32'h1, 64'h0);
      end
    end
    for (int n = 0; n < 40; n++) begin
      seed = lfsr(seed);
      req(1'b1, seed[1:0], {4'h0, seed[5:2]}, {24'h0, seed[15:8]}, {48'h0, seed});
    end
    $display("Test checks done");
    req(1'b1, 2'h0, 8'd1, 32'h1, ccc_pkg::RST_SIZE_LIMIT + 64'h1);
    drv.xfer(1'b0, ccc_pkg::OFS_READINESS, 32'h0, rd);
    chk(rd, 32'h0, "ready after oversize");
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cfg_all("after second reset");
    $display("Test oversize done");
    wrap_up();
  end
endmodule
